// ---- src/ppr_fabric.sv ----
/*
  Peripheral pin routing fabric: input select per peripheral input, output
  function select per bidirectional pin, pad priority mux and mapping lock.
  Assumes pads sit outside with their own input path; a configuration port
  from the core writes the map on clk.
*/
// Contract
// R01: remapping confined to a fixed pin set; each function goes to one pin (outputs: several pins may select the same function)
// R02: bidirectional pins take inputs and outputs; input-only pins take inputs only
// R03: only uart, spi, timer clock, capture, compare and change inputs are routed
// R04: i2c, pwm and analog-input modules are never offered remapping
// R05: a remapped peripheral reaches no pin until software selects one
// R06: fixed peripherals appear on their default pin when active and unopposed
// R07: an active remapped function beats port io and other digital functions
// R08: a remapped function never overrides an analog function on the pin
// R09: separate input and output mapping register sets
// R10: inputs select a pin, outputs select a function
// R11: hardware protection against accidental mapping changes
// R12: while locked, mapping writes are ignored and the map holds
`timescale 1ns/10ps
module ppr_fabric
  import ppr_pkg::*;
#(
  parameter int unsigned N_BIDIR  = PPR_N_BIDIR,
  parameter int unsigned N_INONLY = PPR_N_INONLY,
  parameter int unsigned N_IN_FN  = PPR_N_IN_FN,
  parameter int unsigned N_OUT_FN = PPR_N_OUT_FN
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire ppr_cfg_wr_s                cfg_wr,
  input  wire logic                       cfg_is_out,
  input  wire logic                       lock_set,
  input  wire logic                       lock_clr,
  input  wire logic [PPR_ADDR_W-1:0]      rd_addr,
  input  wire logic                       rd_is_out,
  output logic      [PPR_SEL_W-1:0]       rd_data_q,
  output logic                            locked_q,
  output logic                            wr_blocked_q,
  input  wire logic [N_BIDIR+N_INONLY-1:0] pad_in,
  output logic      [N_BIDIR+N_INONLY-1:0] pad_out_q,
  output logic      [N_BIDIR+N_INONLY-1:0] pad_oe_q,
  input  wire ppr_pin_req_s               pin_req,
  input  wire logic [N_OUT_FN-1:0]        fn_out,
  input  wire logic [N_OUT_FN-1:0]        fn_out_en,
  output logic      [N_IN_FN-1:0]         fn_in_q
);

  localparam int unsigned NP = N_BIDIR + N_INONLY;

  // ****************************************************************
  // pad input synchronisers
  // ****************************************************************
  logic [NP-1:0] s1_q;
  logic [NP-1:0] s2_q;
  logic [NP-1:0] s3_q;
  logic [NP-1:0] pin_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= pad_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts once the last two stages agree
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end

  // ****************************************************************
  // lock
  // ****************************************************************
  // R11: lock guard
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      locked_q <= PPR_LOCK_RESET;
    end else if (lock_set) begin
      locked_q <= 1'b1;
    end else if (lock_clr) begin
      locked_q <= 1'b0;
    end
  end

  logic map_we;
  // R12: drop writes while locked
  assign map_we = cfg_wr.we && !locked_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_blocked_q <= 1'b0;
    end else begin
      wr_blocked_q <= cfg_wr.we && locked_q;
    end
  end

  // ****************************************************************
  // map stores
  // ****************************************************************
  logic [N_IN_FN*PPR_SEL_W-1:0]   in_map;
  logic [N_BIDIR*PPR_SEL_W-1:0]   out_map;
  logic [PPR_SEL_W-1:0]           in_rd_q;
  logic [PPR_SEL_W-1:0]           out_rd_q;
  logic                           rd_is_out_q;

  // R09: two independent register sets
  ppr_map_store #(.WORDS(N_IN_FN), .DATA_W(PPR_SEL_W), .ADDR_W(PPR_ADDR_W)) u_in_map (
    .clk     (clk),
    .nrst    (nrst),
    .we      (map_we && !cfg_is_out),
    .waddr   (cfg_wr.addr),
    .wdata   (cfg_wr.data),
    .raddr   (rd_addr),
    .rdata_q (in_rd_q),
    .all_q   (in_map)
  );

  ppr_map_store #(.WORDS(N_BIDIR), .DATA_W(PPR_SEL_W), .ADDR_W(PPR_ADDR_W)) u_out_map (
    .clk     (clk),
    .nrst    (nrst),
    .we      (map_we && cfg_is_out),
    .waddr   (cfg_wr.addr),
    .wdata   (cfg_wr.data),
    .raddr   (rd_addr),
    .rdata_q (out_rd_q),
    .all_q   (out_map)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_is_out_q <= 1'b0;
    end else begin
      rd_is_out_q <= rd_is_out;
    end
  end

  assign rd_data_q = rd_is_out_q ? out_rd_q : in_rd_q;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // pin select: code 0 means no pin, otherwise pin code-1 if in range
  function automatic logic sel_hits(input logic [PPR_SEL_W-1:0] sel, input int unsigned idx,
                                    input int unsigned limit);
    sel_hits = (sel != PPR_SEL_NONE) && (int'(sel) - 1 == idx) && (idx < limit);
  endfunction

  // ****************************************************************
  // input routing
  // ****************************************************************
  genvar fi;
  genvar pi;
  generate
    for (fi = 0; fi < N_IN_FN; fi++) begin : g_in
      logic [PPR_SEL_W-1:0] sel;
      logic [NP-1:0]        hit;
      assign sel = in_map[fi*PPR_SEL_W +: PPR_SEL_W];
      for (pi = 0; pi < NP; pi++) begin : g_hit
        // R02: any pin in the set can feed an input; R10: input picks a pin
        assign hit[pi] = sel_hits(sel, pi, NP);
      end
      // R05: unassigned input reads idle low; R01: one pin per input
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          fn_in_q[fi] <= 1'b0;
        end else begin
          fn_in_q[fi] <= |(hit & pin_q);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // output routing and pad priority
  // ****************************************************************
  // R03: only the listed digital outputs enter the fabric
  // R04: i2c, pwm and analog modules arrive only through pin_req fixed paths
  genvar po;
  generate
    for (po = 0; po < NP; po++) begin : g_pad
      logic rm_act;
      logic rm_val;
      if (po < N_BIDIR) begin : g_bidir
        logic [PPR_FSEL_W-1:0] fsel;
        logic [PPR_SEL_W-1:0]  code;
        assign code = out_map[po*PPR_SEL_W +: PPR_SEL_W];
        assign fsel = code[PPR_FSEL_W-1:0];
        // R10: output pin picks a function
        always_comb begin
          rm_act = 1'b0;
          rm_val = 1'b0;
          if (code[PPR_SEL_W-1] == 1'b0 && fsel != PPR_FSEL_NONE &&
              int'(fsel) <= N_OUT_FN) begin
            rm_act = fn_out_en[fsel - PPR_FSEL_W'(1)];
            rm_val = fn_out[fsel - PPR_FSEL_W'(1)];
          end
        end
      end else begin : g_inonly
        // R02: input-only pins never carry a remapped output
        assign rm_act = 1'b0;
        assign rm_val = 1'b0;
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pad_out_q[po] <= 1'b0;
          pad_oe_q[po]  <= 1'b0;
        end else if (pin_req.analog_en[po]) begin
          // R08: analog keeps the pin, digital drivers released
          pad_out_q[po] <= 1'b0;
          pad_oe_q[po]  <= 1'b0;
        end else if (rm_act) begin
          // R07: remapped function beats all digital owners
          pad_out_q[po] <= rm_val;
          pad_oe_q[po]  <= 1'b1;
        end else if (pin_req.fixed_oe[po]) begin
          // R06: fixed peripheral on its default pin
          pad_out_q[po] <= pin_req.fixed_o[po];
          pad_oe_q[po]  <= 1'b1;
        end else begin
          pad_out_q[po] <= pin_req.port_o[po];
          pad_oe_q[po]  <= pin_req.port_oe[po];
        end
      end
    end
  endgenerate

endmodule

// ---- src/ppr_pkg.sv ----
/*
  Package for the peripheral pin routing fabric: sizes, select codes,
  reset values and the packed carriers shared by the fabric and its map store.
  Assumes one core clock and an active-low asynchronous system reset.
*/
package ppr_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned PPR_N_BIDIR   = 8;   // bidir_remap_pin count
  localparam int unsigned PPR_N_INONLY  = 4;   // input_only_remap_pin count
  localparam int unsigned PPR_N_PINS    = PPR_N_BIDIR + PPR_N_INONLY;
  localparam int unsigned PPR_N_IN_FN   = 8;   // remappable peripheral inputs
  localparam int unsigned PPR_N_OUT_FN  = 6;   // remappable peripheral outputs
  localparam int unsigned PPR_SEL_W     = 4;   // input select: 0 = none, k = pin k-1
  localparam int unsigned PPR_FSEL_W    = 3;   // output select: 0 = none, k = function k-1
  localparam int unsigned PPR_MAP_WORDS = PPR_N_IN_FN + PPR_N_BIDIR;
  localparam int unsigned PPR_ADDR_W    = 4;

  // ****************************************************************
  // select codes and reset values
  // ****************************************************************
  localparam logic [PPR_SEL_W-1:0]  PPR_SEL_NONE   = 4'h0;
  localparam logic [PPR_FSEL_W-1:0] PPR_FSEL_NONE  = 3'h0;
  localparam logic [PPR_SEL_W-1:0]  PPR_MAP_RESET  = 4'h0;
  localparam logic                  PPR_LOCK_RESET = 1'b0;

  // remappable peripheral input slots; i2c, pwm and converter have none
  typedef enum logic [2:0] {
    PPR_IN_UART_RX  = 3'h0,
    PPR_IN_SPI_SDI  = 3'h1,
    PPR_IN_SPI_SCK  = 3'h2,
    PPR_IN_SPI_SS   = 3'h3,
    PPR_IN_TMR_CLK  = 3'h4,
    PPR_IN_CAPTURE  = 3'h5,
    PPR_IN_CHG_INT  = 3'h6,
    PPR_IN_UART_CTS = 3'h7
  } ppr_in_fn_e;

  // remappable peripheral output slots
  typedef enum logic [2:0] {
    PPR_OUT_UART_TX  = 3'h0,
    PPR_OUT_UART_RTS = 3'h1,
    PPR_OUT_SPI_SDO  = 3'h2,
    PPR_OUT_SPI_SCK  = 3'h3,
    PPR_OUT_SPI_SS   = 3'h4,
    PPR_OUT_COMPARE  = 3'h5
  } ppr_out_fn_e;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic                  we;
    logic [PPR_ADDR_W-1:0] addr;
    logic [PPR_SEL_W-1:0]  data;
  } ppr_cfg_wr_s;

  typedef struct packed {
    logic [PPR_N_PINS-1:0] port_o;
    logic [PPR_N_PINS-1:0] port_oe;
    logic [PPR_N_PINS-1:0] fixed_o;
    logic [PPR_N_PINS-1:0] fixed_oe;
    logic [PPR_N_PINS-1:0] analog_en;
  } ppr_pin_req_s;

endpackage

// ---- src/ppr_map_store.sv ----
/*
  Small mapping memory: one select word per entry, registered read port.
  Assumes writes are already qualified by the caller.
*/
`timescale 1ns/10ps
module ppr_map_store
  import ppr_pkg::*;
#(
  parameter int unsigned WORDS  = PPR_MAP_WORDS,
  parameter int unsigned DATA_W = PPR_SEL_W,
  parameter int unsigned ADDR_W = PPR_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata_q,
  output logic [WORDS*DATA_W-1:0] all_q
);

  // index width of the word array; the address port may be wider
  localparam int unsigned IDX_W = (WORDS > 1) ? $clog2(WORDS) : 1;

  logic [DATA_W-1:0] mem_q [WORDS];

  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_word
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          mem_q[g] <= PPR_MAP_RESET;
        end else if (we && (waddr == ADDR_W'(g))) begin
          mem_q[g] <= wdata;
        end
      end
      assign all_q[g*DATA_W +: DATA_W] = mem_q[g];
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= PPR_MAP_RESET;
    end else if (int'(raddr) < WORDS) begin
      rdata_q <= mem_q[raddr[IDX_W-1:0]];
    end else begin
      rdata_q <= '0;
    end
  end

endmodule

// ---- dv/ppr_pad_model.sv ----
/*
  Pad ring model for the routing fabric.
  Assumes pads are combinational and the board level is set by the bench.
*/
`timescale 1ns/10ps
module ppr_pad_model
  import ppr_pkg::*;
(
  input  wire logic [PPR_N_PINS-1:0] pad_out_q,
  input  wire logic [PPR_N_PINS-1:0] pad_oe_q,
  input  wire logic [PPR_N_PINS-1:0] ext_lvl,
  output logic      [PPR_N_PINS-1:0] pad_in
);
  // a driven pad reads back its own drive, so routed inputs see that drive and ignore ext_lvl
  assign pad_in = (pad_oe_q & pad_out_q) | (~pad_oe_q & ext_lvl);
endmodule

// ---- dv/ppr_fabric_chk.sv ----
/*
  Port checker for the routing fabric.
  Assumes one core clock and the active-low reset of the fabric.
*/
`timescale 1ns/10ps
module ppr_fabric_chk
  import ppr_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire ppr_cfg_wr_s           cfg_wr,
  input wire logic                  lock_set,
  input wire logic                  lock_clr,
  input wire logic [PPR_ADDR_W-1:0] rd_addr,
  input wire logic [PPR_SEL_W-1:0]  rd_data_q,
  input wire logic                  locked_q,
  input wire logic                  wr_blocked_q,
  input wire logic [PPR_N_PINS-1:0] pad_out_q,
  input wire logic [PPR_N_PINS-1:0] pad_oe_q,
  input wire ppr_pin_req_s          pin_req
);
  // input-only pins with an unopposed fixed request
  wire logic [3:0] fx_m = pin_req.fixed_oe[11:8] & ~pin_req.analog_en[11:8];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_lock_on: assert property (lock_set |=> locked_q)
    else $error("lock not set");
  a_lock_off: assert property (lock_clr && !lock_set |=> !locked_q)
    else $error("lock not cleared");
  a_lock_hold: assert property (!lock_set && !lock_clr |=> $stable(locked_q))
    else $error("lock changed by itself");
  a_blk_pulse: assert property (cfg_wr.we && locked_q |=> wr_blocked_q)
    else $error("locked write not flagged");
  a_blk_cause: assert property (wr_blocked_q |-> $past(cfg_wr.we && locked_q))
    else $error("spurious blocked flag");
  a_analog_wins: assert property (((pad_oe_q | pad_out_q) & $past(pin_req.analog_en)) == '0)
    else $error("analog pin driven");
  a_inonly_nomap: assert property (
    (pad_oe_q[11:8] & ~$past(pin_req.port_oe[11:8] | pin_req.fixed_oe[11:8])) == 4'h0)
    else $error("input-only pin driven by remap");
  a_fixed_pin: assert property (((~pad_oe_q[11:8] |
    (pad_out_q[11:8] ^ $past(pin_req.fixed_o[11:8]))) & $past(fx_m)) == 4'h0)
    else $error("fixed function missing");
  a_rd_range: assert property (rd_addr[3] |=> rd_data_q == 4'h0)
    else $error("out of range read not zero");
  c_locked_wr: cover property (wr_blocked_q);
  c_analog: cover property (|pin_req.analog_en);
  c_fixed: cover property (|fx_m);
endmodule
bind ppr_fabric ppr_fabric_chk u_chk (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr),
  .lock_set(lock_set), .lock_clr(lock_clr), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
  .locked_q(locked_q), .wr_blocked_q(wr_blocked_q), .pad_out_q(pad_out_q),
  .pad_oe_q(pad_oe_q), .pin_req(pin_req));

// ---- dv/peripheral_pin_remap_tb.sv ----
/*
  Self-checking bench for the routing fabric with the pad model.
  Assumes the fabric defaults of ppr_pkg.
*/
`timescale 1ns/10ps
module peripheral_pin_remap_tb;
  import ppr_pkg::*;
  logic         clk = 1'b0, nrst = 1'b0, cfg_is_out = 1'b0, rd_is_out = 1'b0;
  logic         lock_set = 1'b0, lock_clr = 1'b0, locked_q, wr_blocked_q;
  ppr_cfg_wr_s  cfg_wr = '0;
  ppr_pin_req_s pin_req = '0;
  logic [3:0]   rd_addr = 4'h0, rd_data_q, v;
  logic [11:0]  ext_lvl = 12'hFFF, pad_in, pad_out_q, pad_oe_q;
  logic [5:0]   fn_out = 6'h00, fn_out_en = 6'h00;
  logic [7:0]   fn_in_q;
  int           error_cnt = 0, checks = 0;

  always #25 clk = ~clk;

  ppr_fabric u_dut (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_is_out(cfg_is_out),
    .lock_set(lock_set), .lock_clr(lock_clr), .rd_addr(rd_addr), .rd_is_out(rd_is_out),
    .rd_data_q(rd_data_q), .locked_q(locked_q), .wr_blocked_q(wr_blocked_q),
    .pad_in(pad_in), .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q), .pin_req(pin_req),
    .fn_out(fn_out), .fn_out_en(fn_out_en), .fn_in_q(fn_in_q));
  ppr_pad_model u_pad (.pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q), .ext_lvl(ext_lvl),
    .pad_in(pad_in));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic o, input logic [3:0] a, input logic [3:0] d);
    @(posedge clk);
    cfg_wr <= '{we: 1'b1, addr: a, data: d};
    cfg_is_out <= o;
    @(posedge clk);
    cfg_wr.we <= 1'b0;
  endtask
  task automatic rd(input logic o, input logic [3:0] a);
    @(posedge clk);
    rd_addr <= a;
    rd_is_out <= o;
    @(posedge clk);
    #1 v = rd_data_q;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    settle(6);
    chk(pad_oe_q, 12'h000);
    chk(fn_in_q, 8'h00);
    rd(1'b0, 4'h0);
    chk(v, 4'h0);
    $display("t_reset done");
  endtask
  task automatic t_out_map;
    @(posedge clk);
    pin_req <= '{port_o: 12'h000, port_oe: 12'hFFF, fixed_o: 12'hFFF,
                 fixed_oe: 12'h302, analog_en: 12'h000};
    for (int f = 0; f < 6; f++) wr(1'b1, f[3:0], f[3:0] + 4'h1);
    wr(1'b1, 4'h8, 4'h1);
    @(posedge clk);
    fn_out <= 6'h15;
    fn_out_en <= 6'h3F;
    settle(2);
    chk(pad_out_q, 12'h315);
    chk(pad_oe_q, 12'hFFF);
    rd(1'b1, 4'h2);
    chk(v, 4'h3);
    rd(1'b1, 4'h8);
    chk(v, 4'h0);
    @(posedge clk);
    pin_req.analog_en <= 12'h101;
    settle(2);
    chk(pad_out_q, 12'h214);
    chk(pad_oe_q, 12'hEFE);
    @(posedge clk);
    pin_req.analog_en <= 12'h000;
    fn_out_en <= 6'h00;
    settle(2);
    chk(pad_out_q, 12'h302);
    $display("t_out_map done");
  endtask
  task automatic t_in_map;
    @(posedge clk);
    pin_req <= '0;
    for (int j = 0; j < 8; j++) wr(1'b0, j[3:0], j[3:0] + 4'h5);
    for (int j = 0; j < 8; j++) begin
      @(posedge clk);
      ext_lvl <= 12'h010 << j;
      settle(6);
      chk(fn_in_q, 8'h01 << j);
    end
    rd(1'b0, 4'h7);
    chk(v, 4'hC);
    $display("t_in_map done");
  endtask
  task automatic t_lock;
    @(posedge clk);
    lock_set <= 1'b1;
    @(posedge clk);
    lock_set <= 1'b0;
    wr(1'b0, 4'h0, 4'h1);
    #1 chk(wr_blocked_q, 1'b1);
    chk(locked_q, 1'b1);
    rd(1'b0, 4'h0);
    chk(v, 4'h5);
    @(posedge clk);
    lock_clr <= 1'b1;
    @(posedge clk);
    lock_clr <= 1'b0;
    wr(1'b0, 4'h0, 4'h1);
    rd(1'b0, 4'h0);
    chk(v, 4'h1);
    $display("t_lock done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_out_map;
    t_in_map;
    t_lock;
    tally_and_finish;
  end

  // the whole run needs about 135 cycles
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule
